//--- mmh_pkg.sv
// constants and carrier types for the memory mailbox handshake engine
package mmh_pkg;

  // ------------------------------------------------------------
  // mailbox word offsets within each remote area
  // ------------------------------------------------------------
  localparam logic [15:0] MMH_OFS_READ = 16'h0000;
  localparam logic [15:0] MMH_OFS_SETCHG = 16'h0001;
  localparam logic [15:0] MMH_OFS_CMD = 16'h0002;
  localparam logic [15:0] MMH_OFS_STAT_CODE = 16'h0003;
  localparam logic [15:0] MMH_OFS_VALUE = 16'h0004;
  localparam int MMH_AREA_WORDS = 5;

  // ------------------------------------------------------------
  // request and response word encodings
  // ------------------------------------------------------------
  localparam logic [15:0] MMH_REQ_STOP = 16'h0000;
  localparam logic [15:0] MMH_REQ_SINGLE = 16'h0001;
  localparam logic [15:0] MMH_REQ_MULTI = 16'h0002;
  localparam logic [15:0] MMH_REQ_RDSET = 16'h0003;
  localparam int MMH_ACT_BIT = 15;

  // ------------------------------------------------------------
  // default remote area bases
  // ------------------------------------------------------------
  localparam logic [15:0] MMH_UPLOAD_BASE = 16'h0000;
  localparam logic [15:0] MMH_DOWNLOAD_BASE = 16'h0100;

  // ------------------------------------------------------------
  // software register offsets and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MMH_REG_CTRL = 8'h00;
  localparam logic [7:0] MMH_REG_SV_MIN = 8'h04;
  localparam logic [7:0] MMH_REG_SV_MAX = 8'h08;
  localparam logic [7:0] MMH_REG_SETVAL = 8'h0c;
  localparam logic [7:0] MMH_REG_STATUS = 8'h10;
  localparam logic [7:0] MMH_REG_CMD = 8'h14;
  localparam int MMH_CTRL_EN_BIT = 0;
  localparam logic [15:0] MMH_SV_MIN_RST = 16'h8000;
  localparam logic [15:0] MMH_SV_MAX_RST = 16'h7fff;
  localparam logic [15:0] MMH_SETVAL_RST = 16'h0000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int MMH_CLK_KHZ = 25000;
  localparam int MMH_POLL_TIME_US = 100;
  localparam int MMH_POLL_CYCLES = MMH_POLL_TIME_US * MMH_CLK_KHZ / 1000;

  // ------------------------------------------------------------
  // remote memory word access carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mmh_mem_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } mmh_mem_rsp_t;

endpackage

//--- mmh_engine.sv
// memory mailbox handshake engine: polls remote request words, answers them
//
// Operation
// R1 - nonzero read request copies upload parameters into remote upload area
// R2 - single read transfers once, then posts the response
// R3 - multi read repeats transfers until request withdrawn
// R4 - single read ends when remote clears request; device then clears response
// R5 - multi read posts response and runs transfers by itself
// R6 - read-setting request uploads download-selected parameters for checking
// R7 - remote stops read with 0000; device finishes transfer, then clears
// R8 - bit 15 of status word toggles after each complete exchange
// R9 - remote writes to monitor word never alter internal settings
// R10 - setting change request reads download area, updates internal settings
// R11 - single setting change writes every value once
// R12 - multi setting change repeats compare-and-write until withdrawn
// R13 - remote writes download values before setting the change request
// R14 - setting change request takes up every download parameter
// R15 - values travel as unscaled integers, decimal point dropped
// R16 - out-of-range set value rejected, previous setting kept
// R17 - remote places command code first; device reads it on request
// R18 - single command executes once; response cleared after request cleared
// R19 - multi command executes on each change of command code
// R20 - five consecutive words per area in fixed order
// R21 - stop request halts only after the series in progress completes
// R22 - request codes: 0 stop, 1 single, 2 multi, 3 read-setting
// R23 - no direct change between nonzero requests; stop must come first
// R24 - accepted request copies its value into the response word
// R25 - request words polled periodically; three request types independent
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module mmh_engine
  import mmh_pkg::*;
#(
  parameter int POLL_CYCLES = MMH_POLL_CYCLES,
  parameter logic [15:0] UPLOAD_BASE = MMH_UPLOAD_BASE,
  parameter logic [15:0] DOWNLOAD_BASE = MMH_DOWNLOAD_BASE
) (
  input wire logic sys_clk,
  input wire logic reset,
  // software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // remote memory word access
  output mmh_mem_req_t mem_req,
  input wire mmh_mem_rsp_t mem_rsp,
  // device side values
  input wire logic [15:0] monitor_value,
  output logic [15:0] set_value,
  output logic cmd_strobe,
  output logic [15:0] cmd_code
);

  // ------------------------------------------------------------
  // types and state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_POLL,
    ST_DECIDE,
    ST_WRITE
  } mmh_state_t;

  localparam int NSLOT = 6;

  mmh_state_t state_reg, state_next;
  logic [15:0] wait_reg, wait_next;
  logic [2:0] idx_reg, idx_next;
  logic [15:0] dl_reg [MMH_AREA_WORDS];
  logic [15:0] dl_next [MMH_AREA_WORDS];
  logic [NSLOT-1:0] mask_reg, mask_next;
  mmh_mem_req_t link_reg, link_next;
  logic [15:0] rd_resp_reg, rd_resp_next;
  logic [15:0] sc_resp_reg, sc_resp_next;
  logic [15:0] cm_resp_reg, cm_resp_next;
  logic [15:0] comm_reg, comm_next;
  logic [15:0] data_reg, data_next;
  logic [15:0] prev_sv_reg, prev_sv_next;
  logic [15:0] last_code_reg, last_code_next;
  logic [15:0] sv_reg, sv_next;
  logic cmd_stb_reg, cmd_stb_next;
  logic [15:0] cmd_reg, cmd_next;
  logic en_reg, en_next;
  logic [15:0] sv_min_reg, sv_min_next;
  logic [15:0] sv_max_reg, sv_max_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] reject_reg, reject_next;

  // slot to remote word: 0 early read response, 1 data, 2 status,
  // 3 late read response, 4 setting response, 5 command response
  function automatic logic [15:0] slot_addr(input logic [2:0] s);
    logic [15:0] ofs;
    ofs = MMH_OFS_READ;
    case (s)
      3'd1: ofs = MMH_OFS_VALUE;
      3'd2: ofs = MMH_OFS_STAT_CODE;
      3'd4: ofs = MMH_OFS_SETCHG;
      3'd5: ofs = MMH_OFS_CMD;
      default: ofs = MMH_OFS_READ;
    endcase
    return UPLOAD_BASE + ofs; // [R20]
  endfunction

  // signed window test for incoming set values
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction

  // ------------------------------------------------------------
  // exchange sequencer: poll, decide, write back
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] rq;
    logic [15:0] sq;
    logic [15:0] cq;
    logic [15:0] code;
    logic [15:0] sv_in;
    logic xfer;
    logic rdset;
    logic take_sv;
    state_next = state_reg;
    wait_next = wait_reg;
    idx_next = idx_reg;
    for (int i = 0; i < MMH_AREA_WORDS; i++) begin
      dl_next[i] = dl_reg[i];
    end
    mask_next = mask_reg;
    link_next = link_reg;
    rd_resp_next = rd_resp_reg;
    sc_resp_next = sc_resp_reg;
    cm_resp_next = cm_resp_reg;
    comm_next = comm_reg;
    data_next = data_reg;
    prev_sv_next = prev_sv_reg;
    last_code_next = last_code_reg;
    sv_next = sv_reg;
    cmd_stb_next = 1'b0;
    cmd_next = cmd_reg;
    reject_next = reject_reg;
    rq = dl_reg[0];
    sq = dl_reg[1];
    cq = dl_reg[2];
    code = dl_reg[3];
    sv_in = dl_reg[4];
    xfer = 1'b0;
    rdset = 1'b0;
    take_sv = 1'b0;

    // software write of the setting; link updates below win
    if (reg_wr && reg_addr == MMH_REG_SETVAL) begin
      sv_next = reg_wdata[15:0];
    end

    case (state_reg)
      // periodic poll timer; idle holds while disabled
      ST_IDLE: begin
        if (!en_reg) begin
          wait_next = '0;
        end else if (wait_reg >= 16'(POLL_CYCLES - 1)) begin // [R25]
          wait_next = '0;
          idx_next = '0;
          state_next = ST_POLL;
        end else begin
          wait_next = wait_reg + 16'h0001;
        end
      end

      // fetch all five download words, one access at a time
      ST_POLL: begin
        if (link_reg.req) begin
          if (mem_rsp.ack) begin
            link_next.req = 1'b0;
            dl_next[idx_reg] = mem_rsp.rdata;
            if (idx_reg == 3'(MMH_AREA_WORDS - 1)) begin
              state_next = ST_DECIDE;
            end else begin
              idx_next = idx_reg + 3'd1;
            end
          end
        end else begin
          link_next.req = 1'b1;
          link_next.we = 1'b0;
          link_next.addr = DOWNLOAD_BASE + 16'(idx_reg); // [R20]
          link_next.wdata = '0;
        end
      end

      // the three request types are judged independently
      ST_DECIDE: begin
        mask_next = '0;
        // read channel
        if (rd_resp_reg == MMH_REQ_STOP) begin
          if (rq == MMH_REQ_SINGLE || rq == MMH_REQ_RDSET) begin // [R22]
            rd_resp_next = rq; // [R24]
            xfer = 1'b1; // [R1] [R2]
            rdset = (rq == MMH_REQ_RDSET);
            mask_next[3] = 1'b1; // response after the transfer [R2]
          end else if (rq == MMH_REQ_MULTI) begin
            rd_resp_next = rq; // [R24]
            xfer = 1'b1; // [R1]
            mask_next[0] = 1'b1; // response before transfers [R5]
          end
        end else if (rq == MMH_REQ_STOP) begin
          // last transfer already finished in an earlier exchange
          rd_resp_next = MMH_REQ_STOP; // [R4] [R7] [R21]
          mask_next[3] = 1'b1;
        end else if (rd_resp_reg == MMH_REQ_MULTI) begin
          // other nonzero values do not switch mode [R23]
          xfer = 1'b1; // [R3] [R5]
        end
        if (xfer) begin
          // monitor or setting, copied raw with no scaling [R15]
          data_next = rdset ? sv_reg : monitor_value; // [R6]
          comm_next = comm_reg ^ (16'h0001 << MMH_ACT_BIT); // [R8]
          mask_next[1] = 1'b1;
          mask_next[2] = 1'b1;
        end

        // setting change channel; upload words never feed back [R9]
        if (sc_resp_reg == MMH_REQ_STOP) begin
          if (sq == MMH_REQ_SINGLE || sq == MMH_REQ_MULTI) begin
            sc_resp_next = sq; // [R24]
            take_sv = 1'b1; // take every download value [R10] [R14]
            mask_next[4] = 1'b1;
          end
        end else if (sq == MMH_REQ_STOP) begin
          sc_resp_next = MMH_REQ_STOP; // [R21]
          mask_next[4] = 1'b1;
        end else if (sc_resp_reg == MMH_REQ_MULTI) begin
          take_sv = (sv_in != prev_sv_reg); // changed values only [R12]
        end
        // single accepts once, so a later poll writes nothing [R11]
        if (take_sv) begin
          prev_sv_next = sv_in;
          if (in_range(sv_in, sv_min_reg, sv_max_reg)) begin
            sv_next = sv_in; // [R10]
          end else begin
            reject_next = reject_reg + 8'h01; // keep old setting [R16]
          end
        end

        // operation command channel
        if (cm_resp_reg == MMH_REQ_STOP) begin
          if (cq == MMH_REQ_SINGLE || cq == MMH_REQ_MULTI) begin
            cm_resp_next = cq; // [R24]
            cmd_stb_next = 1'b1; // code read with request [R17] [R18]
            cmd_next = code;
            last_code_next = code;
            mask_next[5] = 1'b1;
          end
        end else if (cq == MMH_REQ_STOP) begin
          cm_resp_next = MMH_REQ_STOP; // [R18] [R21]
          mask_next[5] = 1'b1;
        end else if (cm_resp_reg == MMH_REQ_MULTI &&
                     code != last_code_reg) begin
          cmd_stb_next = 1'b1; // [R19]
          cmd_next = code;
          last_code_next = code;
        end
        idx_next = '0;
        state_next = ST_WRITE;
      end

      // write back the chosen upload words in slot order
      ST_WRITE: begin
        if (link_reg.req) begin
          if (mem_rsp.ack) begin
            link_next.req = 1'b0;
            if (idx_reg == 3'(NSLOT - 1)) begin
              state_next = ST_IDLE;
            end else begin
              idx_next = idx_reg + 3'd1;
            end
          end
        end else if (mask_reg[idx_reg]) begin
          link_next.req = 1'b1;
          link_next.we = 1'b1;
          link_next.addr = slot_addr(idx_reg);
          case (idx_reg)
            3'd1: link_next.wdata = data_reg;
            3'd2: link_next.wdata = comm_reg;
            3'd4: link_next.wdata = sc_resp_reg;
            3'd5: link_next.wdata = cm_resp_reg;
            default: link_next.wdata = rd_resp_reg;
          endcase
        end else if (idx_reg == 3'(NSLOT - 1)) begin
          state_next = ST_IDLE;
        end else begin
          idx_next = idx_reg + 3'd1;
        end
      end

      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      wait_reg <= '0;
      idx_reg <= '0;
      for (int i = 0; i < MMH_AREA_WORDS; i++) begin
        dl_reg[i] <= '0;
      end
      mask_reg <= '0;
      link_reg <= '0;
      rd_resp_reg <= MMH_REQ_STOP;
      sc_resp_reg <= MMH_REQ_STOP;
      cm_resp_reg <= MMH_REQ_STOP;
      comm_reg <= '0;
      data_reg <= '0;
      prev_sv_reg <= '0;
      last_code_reg <= '0;
      sv_reg <= MMH_SETVAL_RST;
      cmd_stb_reg <= 1'b0;
      cmd_reg <= '0;
      reject_reg <= '0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      idx_reg <= idx_next;
      for (int i = 0; i < MMH_AREA_WORDS; i++) begin
        dl_reg[i] <= dl_next[i];
      end
      mask_reg <= mask_next;
      link_reg <= link_next;
      rd_resp_reg <= rd_resp_next;
      sc_resp_reg <= sc_resp_next;
      cm_resp_reg <= cm_resp_next;
      comm_reg <= comm_next;
      data_reg <= data_next;
      prev_sv_reg <= prev_sv_next;
      last_code_reg <= last_code_next;
      sv_reg <= sv_next;
      cmd_stb_reg <= cmd_stb_next;
      cmd_reg <= cmd_next;
      reject_reg <= reject_next;
    end
  end

  // ------------------------------------------------------------
  // software register port
  // ------------------------------------------------------------
  // control and range limits; read data valid only the cycle after
  always_comb begin
    en_next = en_reg;
    sv_min_next = sv_min_reg;
    sv_max_next = sv_max_reg;
    rdata_next = '0;
    if (reg_wr) begin
      case (reg_addr)
        MMH_REG_CTRL: en_next = reg_wdata[MMH_CTRL_EN_BIT];
        MMH_REG_SV_MIN: sv_min_next = reg_wdata[15:0];
        MMH_REG_SV_MAX: sv_max_next = reg_wdata[15:0];
        default: en_next = en_reg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        MMH_REG_CTRL: rdata_next = {31'h0, en_reg};
        MMH_REG_SV_MIN: rdata_next = {16'h0, sv_min_reg};
        MMH_REG_SV_MAX: rdata_next = {16'h0, sv_max_reg};
        MMH_REG_SETVAL: rdata_next = {16'h0, sv_reg};
        MMH_REG_STATUS: rdata_next = {reject_reg, comm_reg[MMH_ACT_BIT],
                                      1'b0, cm_resp_reg[1:0],
                                      sc_resp_reg[1:0], rd_resp_reg[1:0],
                                      16'h0};
        MMH_REG_CMD: rdata_next = {16'h0, cmd_reg};
        default: rdata_next = '0; // unmapped reads as zero
      endcase
    end
  end

  // register port flip-flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      en_reg <= 1'b0;
      sv_min_reg <= MMH_SV_MIN_RST;
      sv_max_reg <= MMH_SV_MAX_RST;
      rdata_reg <= '0;
    end else begin
      en_reg <= en_next;
      sv_min_reg <= sv_min_next;
      sv_max_reg <= sv_max_next;
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign mem_req = link_reg;
  assign set_value = sv_reg;
  assign cmd_strobe = cmd_stb_reg;
  assign cmd_code = cmd_reg;

endmodule

`default_nettype wire

//--- mmh_checker.sv
// assertion checker for the mailbox engine link and command outputs
`timescale 1ns/100ps
`default_nettype none
module mmh_checker
  import mmh_pkg::*;
#(
  parameter logic [15:0] UPLOAD_BASE = MMH_UPLOAD_BASE,
  parameter logic [15:0] DOWNLOAD_BASE = MMH_DOWNLOAD_BASE
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire mmh_mem_req_t mem_req,
  input wire mmh_mem_rsp_t mem_rsp,
  input wire logic cmd_strobe,
  input wire logic [15:0] cmd_code
);
  // ----------------------------------------------------------
  // link, mailbox and command checks
  // ----------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [15:0] ofs_up;
  logic [15:0] ofs_dn;
  logic rd_acc;
  logic wr_acc;
  // word offsets; wrap makes below-base addresses large
  assign ofs_up = mem_req.addr - UPLOAD_BASE;
  assign ofs_dn = mem_req.addr - DOWNLOAD_BASE;
  assign rd_acc = mem_req.req && !mem_req.we;
  assign wr_acc = mem_req.req && mem_req.we;
  chk_req_hold: assert property (mem_req.req && !mem_rsp.ack |=>
    mem_req.req && $stable(mem_req)) else $error("link request moved");
  chk_req_drop: assert property (mem_req.req && mem_rsp.ack |=>
    !mem_req.req) else $error("link request held after ack");
  chk_read_area: assert property (rd_acc |-> ofs_dn < 16'h0005)
    else $error("read outside download area");
  chk_write_area: assert property (wr_acc |-> ofs_up < 16'h0005)
    else $error("write outside upload area");
  chk_read_resp: assert property (wr_acc && ofs_up == 16'h0000
    |-> mem_req.wdata <= MMH_REQ_RDSET) else $error("bad read response");
  chk_other_resp: assert property (wr_acc && (ofs_up == 16'h0001
    || ofs_up == 16'h0002) |-> mem_req.wdata <= MMH_REQ_MULTI)
    else $error("bad response code");
  chk_status_low: assert property (wr_acc && ofs_up == 16'h0003
    |-> mem_req.wdata[14:0] == 15'h0000) else $error("status low bits");
  chk_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe longer than one cycle");
  chk_code_change: assert property ($changed(cmd_code) |-> cmd_strobe)
    else $error("command code moved without strobe");
endmodule
bind mmh_engine mmh_checker #(
  .UPLOAD_BASE(UPLOAD_BASE),
  .DOWNLOAD_BASE(DOWNLOAD_BASE)
) u_mmh_checker (
  .sys_clk(sys_clk),
  .reset(reset),
  .mem_req(mem_req),
  .mem_rsp(mem_rsp),
  .cmd_strobe(cmd_strobe),
  .cmd_code(cmd_code)
);
`default_nettype wire

//--- mmh_plc_model.sv
// remote controller memory model answering word accesses over the link
`timescale 1ns/100ps
`default_nettype none
module mmh_plc_model
  import mmh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire mmh_mem_req_t mem_req,
  output mmh_mem_rsp_t mem_rsp
);
  // ----------------------------------------------------------
  // word store and ack timing
  // ----------------------------------------------------------
  logic [15:0] mem [512];
  int lat = 1; // ack latency, raised by the bench for slow runs
  int wait_cnt = 0;
  initial begin
    mem_rsp = '0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // one ack pulse per request; released data inverts so no stale match
  always @(posedge sys_clk) begin
    if (reset || mem_rsp.ack || !mem_req.req) begin
      mem_rsp.ack <= 1'b0;
      mem_rsp.rdata <= ~mem_rsp.rdata;
      wait_cnt <= 0;
    end else if (wait_cnt + 1 >= lat) begin
      mem_rsp.ack <= 1'b1;
      if (mem_req.we) begin
        mem[mem_req.addr[8:0]] <= mem_req.wdata;
      end else begin
        mem_rsp.rdata <= mem[mem_req.addr[8:0]];
      end
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the memory mailbox handshake engine
`timescale 1ns/100ps
`default_nettype none
module tb
  import mmh_pkg::*;
;
  // ----------------------------------------------------------
  // signals, instances and clock
  // ----------------------------------------------------------
  localparam int UP = MMH_UPLOAD_BASE;
  localparam int DN = MMH_DOWNLOAD_BASE;
  logic sys_clk, reset, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] monitor_value, set_value, cmd_code;
  logic cmd_strobe;
  mmh_mem_req_t mem_req;
  mmh_mem_rsp_t mem_rsp;
  int n_errors = 0;
  int n_compared = 0;
  int n_strobe = 0;
  int cyc = 0;
  int i, k;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  logic [31:0] rv [7] = '{32'h0, 32'h8000, 32'h7fff, 32'h0, 32'h0, 32'h0,
    32'h0};
  mmh_engine #(.POLL_CYCLES(4)) u_mmh_engine (.sys_clk(sys_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .monitor_value(monitor_value),
    .set_value(set_value), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code));
  mmh_plc_model u_plc (.sys_clk(sys_clk), .reset(reset),
    .mem_req(mem_req), .mem_rsp(mem_rsp));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // strobe counter and hang guard, ceiling well above the run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cmd_strobe === 1'b1) n_strobe++;
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check("register", reg_rdata, e);
  endtask
  // remote side writes its memory away from the model's sampling edge
  task automatic put(input int a, input logic [15:0] v);
    @(negedge sys_clk);
    u_plc.mem[a] = v;
  endtask
  task automatic word_wait(input int a, input logic [15:0] v);
    for (int j = 0; j < 3000 && u_plc.mem[a] !== v; j++) @(posedge sys_clk);
    check("remote word", u_plc.mem[a], v);
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    monitor_value = 16'h03e8;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) reg_chk(ra[i], rv[i]);
    reg_write(MMH_REG_CTRL, 32'h1);
    reg_chk(MMH_REG_CTRL, 32'h1);
    // single read, then a refused direct change to multi
    put(DN, MMH_REQ_SINGLE);
    word_wait(UP, MMH_REQ_SINGLE);
    check("monitor", u_plc.mem[UP + 4], 16'h03e8);
    check("status", u_plc.mem[UP + 3], 16'h8000);
    reg_chk(MMH_REG_STATUS, 32'h0081_0000);
    put(DN, MMH_REQ_MULTI);
    repeat (200) @(posedge sys_clk);
    check("read resp", u_plc.mem[UP], MMH_REQ_SINGLE);
    put(DN, MMH_REQ_STOP);
    word_wait(UP, MMH_REQ_STOP);
    // multi read over a slow link, then stop
    u_plc.lat = 6;
    put(DN, MMH_REQ_MULTI);
    word_wait(UP, MMH_REQ_MULTI);
    @(posedge sys_clk) monitor_value <= 16'h1234;
    word_wait(UP + 4, 16'h1234);
    put(DN, MMH_REQ_STOP);
    word_wait(UP, MMH_REQ_STOP);
    @(posedge sys_clk) monitor_value <= 16'h5555;
    repeat (200) @(posedge sys_clk);
    check("stopped", u_plc.mem[UP + 4], 16'h1234);
    u_plc.lat = 1;
    // single setting change, values placed before the request
    put(DN + 4, 16'h03e8);
    put(DN + 1, MMH_REQ_SINGLE);
    word_wait(UP + 1, MMH_REQ_SINGLE);
    check("set value", set_value, 16'h03e8);
    reg_chk(MMH_REG_SETVAL, 32'h03e8);
    put(DN + 1, MMH_REQ_STOP);
    word_wait(UP + 1, MMH_REQ_STOP);
    // read-setting uploads the held setting, not the monitor
    put(DN, MMH_REQ_RDSET);
    word_wait(UP, MMH_REQ_RDSET);
    check("read setting", u_plc.mem[UP + 4], 16'h03e8);
    put(DN, MMH_REQ_STOP);
    word_wait(UP, MMH_REQ_STOP);
    // out-of-range value is refused
    reg_write(MMH_REG_SV_MAX, 32'h0100);
    put(DN + 4, 16'h0200);
    put(DN + 1, MMH_REQ_SINGLE);
    word_wait(UP + 1, MMH_REQ_SINGLE);
    check("range", set_value, 16'h03e8);
    put(DN + 1, MMH_REQ_STOP);
    word_wait(UP + 1, MMH_REQ_STOP);
    // multi setting change follows a later edit
    put(DN + 1, MMH_REQ_MULTI);
    word_wait(UP + 1, MMH_REQ_MULTI);
    put(DN + 4, 16'h0050);
    for (i = 0; i < 2000 && set_value !== 16'h0050; i++) @(posedge sys_clk);
    check("multi set", set_value, 16'h0050);
    put(DN + 1, MMH_REQ_STOP);
    word_wait(UP + 1, MMH_REQ_STOP);
    put(UP + 4, 16'h7777);
    repeat (200) @(posedge sys_clk);
    check("monitor write", set_value, 16'h0050);
    // single command, code placed before the request
    put(DN + 3, 16'h2808);
    put(DN + 2, MMH_REQ_SINGLE);
    word_wait(UP + 2, MMH_REQ_SINGLE);
    check("cmd code", cmd_code, 16'h2808);
    repeat (200) @(posedge sys_clk);
    check("cmd count", n_strobe, 1);
    put(DN + 2, MMH_REQ_STOP);
    word_wait(UP + 2, MMH_REQ_STOP);
    // multi command runs once per code change
    put(DN + 2, MMH_REQ_MULTI);
    word_wait(UP + 2, MMH_REQ_MULTI);
    repeat (50) @(posedge sys_clk);
    k = n_strobe;
    put(DN + 3, 16'h2c08);
    repeat (200) @(posedge sys_clk);
    check("multi cmd", n_strobe, k + 1);
    check("cmd code", cmd_code, 16'h2c08);
    reg_chk(MMH_REG_CMD, 32'h2c08);
    put(DN + 2, MMH_REQ_STOP);
    word_wait(UP + 2, MMH_REQ_STOP);
    // direct register access and unmapped place
    reg_write(MMH_REG_SETVAL, 32'h0042);
    reg_chk(MMH_REG_SETVAL, 32'h0042);
    reg_write(8'h20, 32'hffff_ffff);
    reg_chk(8'h20, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
